// >>> design/rtcif_pkg.sv
// constants for the rtc interrupt and flag logic: register map, fields, reset values, timing
// assumes an ahb-lite master with whole-word accesses and a 65.536 kHz edge tick
// Function
// - set backup-supply fail flag when backup voltage drops below threshold; report later
// - keep watching backup supply while on backup power and record low voltage
// - interrupt only when a source flag rises and its enable bit is one
// - pulse mode drives pin about 200 ms; level mode holds until flags/control read
// - no pin interrupts generated while running from backup power; the irq status still sets
// - disabled source only sets its flag and leaves the pin alone
// - square-wave enable puts selected wave on pin, overriding interrupt sources
// - select 00=1 Hz, 01=512 Hz, 10=4096 Hz, 11=32768 Hz
// - calibration bit puts 512 Hz on pin above square wave and interrupts
// - calibration bit clears at power-up; wave bits restored from stored copy
// - polarity one: active-high push-pull; zero: active-low open-drain
// - flags read clears the event flags, ends level hold and cuts a pulse short
// - four event flags: watchdog, alarm, power fail, backup fail, cleared by reading
// - flags load zero at power-up, the oscillator-fail bit included
// - pin priority: backup power releases it, then calibration, then square wave, then interrupts, else high-z
package rtcif_pkg;

  // printed offsets are word indices; byte address is four times the index
  localparam logic [31:0] IDX_INT_CTRL = 32'h0001_fff6;
  localparam logic [31:0] IDX_FLAGS = 32'h001f_fff0;
  localparam logic [31:0] ADDR_INT_CTRL = IDX_INT_CTRL << 2;
  localparam logic [31:0] ADDR_FLAGS = IDX_FLAGS << 2;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h0000_0008;

  // interrupt_control fields
  localparam int CTL_WDOG_IE = 7;
  localparam int CTL_ALARM_IE = 6;
  localparam int CTL_PFAIL_IE = 5;
  localparam int CTL_SQW_EN = 4;
  localparam int CTL_ACT_HIGH = 3;
  localparam int CTL_PULSE = 2;
  localparam int CTL_FSEL_HI = 1;
  localparam int CTL_FSEL_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h08;
  localparam logic [7:0] CTL_NV_MASK = 8'h13;

  // event_flags fields
  localparam int FLG_WDOG = 7;
  localparam int FLG_ALARM = 6;
  localparam int FLG_PFAIL = 5;
  localparam int FLG_OSC = 4;
  localparam int FLG_BKUP = 3;
  localparam int FLG_CAL = 2;
  localparam int FLG_WEN = 1;
  localparam int FLG_RD = 0;
  localparam logic [7:0] FLG_RESET = 8'h00;

  // irq status/enable layout: watchdog, alarm, power fail, backup fail
  localparam int NUM_IRQ = 4;
  localparam logic [NUM_IRQ-1:0] IRQ_RESET = 4'h0;

  // square-wave select codes and prescaler taps (edge tick is twice the oscillator)
  localparam logic [1:0] FSEL_1HZ = 2'b00;
  localparam logic [1:0] FSEL_512HZ = 2'b01;
  localparam logic [1:0] FSEL_4096HZ = 2'b10;
  localparam logic [1:0] FSEL_32768HZ = 2'b11;
  localparam int TAP_1HZ = 15;
  localparam int TAP_512HZ = 6;
  localparam int TAP_4096HZ = 3;
  localparam int TAP_32768HZ = 0;
  localparam int PRESC_W = 16;

  // pulse width, counted in edge ticks
  localparam int PULSE_MS = 200;
  localparam int EDGE_TICK_HZ = 65536;
  localparam int PULSE_TICKS = (PULSE_MS * EDGE_TICK_HZ) / 1000;
  localparam int PULSE_W = 14;
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_TICKS[PULSE_W-1:0];

endpackage

// >>> design/rtcif_flag.sv
// a row of sticky flags with set over clear
// assumes set and clear are synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module rtcif_flag #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output var logic [WIDTH-1:0] flag_q
);

  // an event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= set | (flag_q & ~clr);
    end
  end

endmodule
`default_nettype wire

// >>> design/rtcif_int_logic.sv
// interrupt, flag and pin-mux logic of the rtc, with an ahb-lite register slave
// assumes one hclk domain; event inputs and osc_edge_tick are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module rtcif_int_logic
  import rtcif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic osc_edge_tick,
  input wire logic watchdog_timeout,
  input wire logic alarm_match,
  input wire logic power_fail,
  input wire logic backup_below_threshold,
  input wire logic on_backup_power,
  input wire logic oscillator_fail,
  input wire logic nv_recall,
  input wire logic [7:0] nv_int_cfg,
  output logic [7:0] int_cfg_to_store,
  output logic int_pin_o,
  output logic int_pin_oe,
  output logic irq
);

  logic [31:0] addr_q;
  logic wr_q;
  logic [31:0] hrdata_q;
  logic [7:0] ctrl_q;
  logic oscillator_fail_flag_q;
  logic cal_q;
  logic wen_q;
  logic rd_bit_q;
  logic lvl_q;
  logic [PULSE_W-1:0] pulse_q;
  logic [PRESC_W-1:0] presc_q;
  logic bkup_low_q;
  logic int_o_q;
  logic int_oe_q;
  logic [NUM_IRQ-1:0] irq_en_q;
  logic [NUM_IRQ-1:0] irq_stat_q;
  logic [3:0] evt_flags_q;
  logic [3:0] evt_set;
  logic [3:0] evt_clr;
  logic [NUM_IRQ-1:0] stat_set;
  logic [NUM_IRQ-1:0] stat_clr;
  logic ap_valid;
  logic rd_flags;
  logic rd_ctrl;
  logic wr_ctrl;
  logic wr_flags;
  logic [2:0] src_en;
  logic new_irq;
  logic irq_active;
  logic wave;
  logic wave_sel;
  logic int_o_d;
  logic int_oe_d;
  logic [7:0] flags_view;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign int_pin_o = int_o_q;
  assign int_pin_oe = int_oe_q;
  assign int_cfg_to_store = ctrl_q & CTL_NV_MASK;

  // address phase: reads are answered from the value at this edge, so side
  // effects of a read happen here and the data phase needs no wait state
  assign ap_valid = hsel && htrans[1] && hready;
  assign rd_flags = ap_valid && !hwrite && (haddr == ADDR_FLAGS);
  assign rd_ctrl = ap_valid && !hwrite && (haddr == ADDR_INT_CTRL);
  assign wr_ctrl = wr_q && (addr_q == ADDR_INT_CTRL);
  assign wr_flags = wr_q && (addr_q == ADDR_FLAGS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 32'h0000_0000;
      wr_q <= 1'b0;
    end else if (hready) begin
      addr_q <= haddr;
      wr_q <= ap_valid && hwrite;
    end
  end

  assign flags_view = {evt_flags_q[3], evt_flags_q[2], evt_flags_q[1], oscillator_fail_flag_q,
                       evt_flags_q[0], cal_q, wen_q, rd_bit_q};

  // read data, unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      if (haddr == ADDR_FLAGS) begin
        hrdata_q <= {24'h00_0000, flags_view};
      end else if (haddr == ADDR_INT_CTRL) begin
        hrdata_q <= {24'h00_0000, ctrl_q};
      end else if (haddr == ADDR_IRQ_STATUS) begin
        hrdata_q <= {28'h000_0000, irq_stat_q};
      end else if (haddr == ADDR_IRQ_ENABLE) begin
        hrdata_q <= {28'h000_0000, irq_en_q};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // interrupt control; wave bits come back from the stored copy at recall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[7:0];
    end else if (nv_recall) begin
      ctrl_q <= (ctrl_q & ~CTL_NV_MASK) | (nv_int_cfg & CTL_NV_MASK);
    end
  end

  // write-enable gates the other writable flag bits; cal is volatile
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen_q <= 1'b0;
      cal_q <= 1'b0;
      rd_bit_q <= 1'b0;
    end else if (wr_flags) begin
      wen_q <= hwdata[FLG_WEN];
      if (wen_q) begin
        cal_q <= hwdata[FLG_CAL];
        rd_bit_q <= hwdata[FLG_RD];
      end
    end
  end

  // oscillator-fail keeps its own behaviour: not cleared by a read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oscillator_fail_flag_q <= 1'b0;
    end else if (oscillator_fail) begin
      oscillator_fail_flag_q <= 1'b1;
    end else if (wr_flags && wen_q && !hwdata[FLG_OSC]) begin
      oscillator_fail_flag_q <= 1'b0;
    end
  end

  // backup monitor stays armed on backup power too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bkup_low_q <= 1'b0;
    end else begin
      bkup_low_q <= backup_below_threshold;
    end
  end

  // event flags {watchdog, alarm, power fail, backup fail}, cleared by a read
  assign evt_set = {watchdog_timeout, alarm_match, power_fail,
                    backup_below_threshold};
  assign evt_clr = {4{rd_flags}};

  rtcif_flag #(
    .WIDTH(4)
  ) u_evt_flags (
    .clk(hclk),
    .rst_n(hresetn),
    .set(evt_set),
    .clr(evt_clr),
    .flag_q(evt_flags_q)
  );

  // a disabled source only leaves its flag behind
  assign src_en = {ctrl_q[CTL_WDOG_IE], ctrl_q[CTL_ALARM_IE], ctrl_q[CTL_PFAIL_IE]};
  assign new_irq = |({watchdog_timeout, alarm_match, power_fail} & src_en)
                   && !on_backup_power;

  // level mode hold, ended by reading flags or control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= 1'b0;
    end else if (new_irq) begin
      lvl_q <= 1'b1;
    end else if (rd_flags || rd_ctrl) begin
      lvl_q <= 1'b0;
    end
  end

  // pulse timer on the oscillator tick, restarted by every enabled event while not on backup power
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_q <= '0;
    end else if (new_irq) begin
      pulse_q <= PULSE_LOAD;
    end else if (rd_flags || rd_ctrl) begin
      pulse_q <= '0;
    end else if (osc_edge_tick && (pulse_q != '0)) begin
      pulse_q <= pulse_q - 1'b1;
    end
  end

  assign irq_active = (ctrl_q[CTL_PULSE] ? (pulse_q != '0) : lvl_q)
                      && !on_backup_power;

  // free-running prescaler; bit 0 toggles at the oscillator rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= '0;
    end else if (osc_edge_tick) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  always_comb begin
    case ({ctrl_q[CTL_FSEL_HI], ctrl_q[CTL_FSEL_LO]})
      FSEL_1HZ: wave_sel = presc_q[TAP_1HZ];
      FSEL_512HZ: wave_sel = presc_q[TAP_512HZ];
      FSEL_4096HZ: wave_sel = presc_q[TAP_4096HZ];
      default: wave_sel = presc_q[TAP_32768HZ];
    endcase
  end

  // pin mux: released on backup power, then calibration clock, then square wave, then interrupt, else released
  always_comb begin
    wave = 1'b0;
    int_o_d = 1'b0;
    int_oe_d = 1'b0;
    if (on_backup_power) begin
      int_oe_d = 1'b0;
    end else if (cal_q || ctrl_q[CTL_SQW_EN]) begin
      wave = cal_q ? presc_q[TAP_512HZ] : wave_sel;
      if (ctrl_q[CTL_ACT_HIGH]) begin
        int_o_d = wave;
        int_oe_d = 1'b1;
      end else begin
        int_oe_d = !wave;
      end
    end else if (|src_en) begin
      if (ctrl_q[CTL_ACT_HIGH]) begin
        int_o_d = irq_active;
        int_oe_d = 1'b1;
      end else begin
        int_oe_d = irq_active;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_o_q <= 1'b0;
      int_oe_q <= 1'b0;
    end else begin
      int_o_q <= int_o_d;
      int_oe_q <= int_oe_d;
    end
  end

  // system interrupt: sticky status, enable mask, write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= IRQ_RESET;
    end else if (wr_q && (addr_q == ADDR_IRQ_ENABLE)) begin
      irq_en_q <= hwdata[NUM_IRQ-1:0];
    end
  end

  assign stat_set = {watchdog_timeout, alarm_match, power_fail,
                     backup_below_threshold && !bkup_low_q};
  assign stat_clr = (wr_q && (addr_q == ADDR_IRQ_CLEAR)) ? hwdata[NUM_IRQ-1:0]
                                                         : IRQ_RESET;

  rtcif_flag #(
    .WIDTH(NUM_IRQ)
  ) u_irq_stat (
    .clk(hclk),
    .rst_n(hresetn),
    .set(stat_set),
    .clr(stat_clr),
    .flag_q(irq_stat_q)
  );

  assign irq = |(irq_stat_q & irq_en_q);

  // hsize is not checked: only whole-word accesses are expected
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0]};

endmodule
`default_nettype wire

// >>> testbench/rtcif_int_monitor.sv
// concurrent checks on the ports of rtcif_int_logic
// assumes one hclk domain and the map of rtcif_pkg
`timescale 1ns/10ps
`default_nettype none
module rtcif_int_monitor
  import rtcif_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic watchdog_timeout,
  input wire logic alarm_match,
  input wire logic power_fail,
  input wire logic backup_below_threshold,
  input wire logic on_backup_power,
  input wire logic nv_recall,
  input wire logic [7:0] int_cfg_to_store,
  input wire logic int_pin_o,
  input wire logic int_pin_oe,
  input wire logic irq
);
  wire logic take = hsel && htrans[1] && hready;
  wire logic rd = take && !hwrite;
  wire logic cw = take && hwrite && haddr == ADDR_INT_CTRL;
  wire logic iw = take && hwrite && (haddr == ADDR_IRQ_CLEAR || haddr == ADDR_IRQ_ENABLE);
  wire logic ev = watchdog_timeout || alarm_match || power_fail || backup_below_threshold;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_hold: assert property (!$past(rd) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_pin_drive: assert property (int_pin_o |-> int_pin_oe)
    else $error("pin high while released");
  a_backup_quiet: assert property (on_backup_power && $past(on_backup_power)
    && $past(on_backup_power, 2) |-> !int_pin_oe) else $error("pin driven on backup");
  a_cfg_source: assert property ($changed(int_cfg_to_store)
    |-> $past(cw, 2) || $past(nv_recall)) else $error("stored image changed alone");
  a_irq_rise: assert property ($rose(irq)
    |-> $past(ev) || $past(ev, 2) || $past(iw, 2)) else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(iw, 2))
    else $error("irq fell without a write");
endmodule
bind rtcif_int_logic rtcif_int_monitor i_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .watchdog_timeout, .alarm_match,
  .power_fail, .backup_below_threshold, .on_backup_power, .nv_recall, .int_cfg_to_store,
  .int_pin_o, .int_pin_oe, .irq);
`default_nettype wire

// >>> testbench/rtcif_host_model.sv
// host side of the interrupt pin: pull-up, wire level and a transition counter
// assumes the pin registers change just after rising clock edges
`timescale 1ns/10ps
`default_nettype none
module rtcif_host_model #(
  parameter int IGNORE_CYC = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin,
  output var int edges
);
  int age;
  logic prev;
  // open-drain low mode relies on this pull-up
  assign pin = pin_oe ? pin_o : 1'b1;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 0;
      prev <= 1'b1;
      edges <= 0;
    end else begin
      prev <= pin;
      // pin activity right after power-up is not trusted
      if (age < IGNORE_CYC) age <= age + 1;
      else if (pin !== prev) edges <= edges + 1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for rtcif_int_logic: ahb-lite master, events, read scoreboard
// assumes the edge tick runs every cycle, so a pulse lasts PULSE_TICKS cycles
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import rtcif_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, nv_recall = 0;
  logic bk_lo = 0, on_bk = 0, dph = 0, osc_f = 0;
  logic [2:0] ev = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [7:0] nvc = 0, cfg;
  logic pin_o, pin_oe, irq, hresp, pin;
  wire logic hrdy;
  int edges, e0, r, fail_count = 0, samples_checked = 0;
  int hz[4] = '{1, 512, 4096, 32768};
  logic [31:0] exq[$];
  always #2 hclk = ~hclk;
  rtcif_int_logic i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp, .osc_edge_tick(1'b1),
    .watchdog_timeout(ev[0]), .alarm_match(ev[1]), .power_fail(ev[2]),
    .backup_below_threshold(bk_lo), .on_backup_power(on_bk), .oscillator_fail(osc_f),
    .nv_recall, .nv_int_cfg(nvc), .int_cfg_to_store(cfg), .int_pin_o(pin_o),
    .int_pin_oe(pin_oe), .irq);
  rtcif_host_model i_host (.clk(hclk), .rst_n(hresetn), .pin_o, .pin_oe, .pin, .edges);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    if (!w) exq.push_back(d);
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    if (w) hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
  endtask
  task automatic pulse(input int k);
    @(posedge hclk);
    ev <= 3'b001 << k;
    @(posedge hclk);
    ev <= 3'b000;
    repeat (3) @(posedge hclk);
  endtask
  task automatic pin_is(input logic v);
    repeat (3) @(negedge hclk);
    check(pin, v);
    // hand back on a rising edge so the next stimulus is launched there
    @(posedge hclk);
  endtask
  task automatic count(output int n);
    repeat (16) @(posedge hclk);
    e0 = edges;
    repeat (2048) @(posedge hclk);
    n = edges - e0;
  endtask
  // read results land at the end of the data phase
  always @(posedge hclk) begin
    if (dph && hrdy === 1'b1) check(hrdata, exq.pop_front());
    dph <= hsel && htrans[1] && !hwrite && hrdy;
  end
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  initial begin
    r = $urandom(5);
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    bus(0, ADDR_INT_CTRL, 32'h0000_0008);
    bus(0, ADDR_FLAGS, 32'h0000_0000);
    bus(1, 32'h0000_0100, $urandom);
    bus(0, 32'h0000_0100, 32'h0000_0000);
    bus(1, ADDR_INT_CTRL, 32'h0000_0080);
    pulse(1);
    pin_is(1'b1);
    bus(0, ADDR_FLAGS, 32'h0000_0040);
    pulse(0);
    pin_is(1'b0);
    repeat (50) @(posedge hclk);
    pin_is(1'b0);
    bus(0, ADDR_FLAGS, 32'h0000_0080);
    pin_is(1'b1);
    on_bk <= 1;
    pulse(0);
    bk_lo <= 1;
    pin_is(1'b1);
    bk_lo <= 0;
    on_bk <= 0;
    pin_is(1'b1);
    bus(0, ADDR_FLAGS, 32'h0000_0088);
    bus(1, ADDR_INT_CTRL, 32'h0000_008c);
    pulse(0);
    repeat (6000) @(posedge hclk);
    pulse(0);
    repeat (10000) @(posedge hclk);
    pin_is(1'b1);
    repeat (4000) @(posedge hclk);
    pin_is(1'b0);
    pulse(0);
    bus(0, ADDR_FLAGS, 32'h0000_0080);
    pin_is(1'b0);
    bus(1, ADDR_INT_CTRL, 32'h0000_0060);
    pulse(2);
    pin_is(1'b0);
    bus(0, ADDR_INT_CTRL, 32'h0000_0060);
    pin_is(1'b1);
    bus(0, ADDR_FLAGS, 32'h0000_0020);
    for (int s = 0; s < 4; s++) begin
      bus(1, ADDR_INT_CTRL, 32'h0000_0018 | s);
      count(r);
      if (s == 0) check(r < 2, 1'b1);
      else check(r, hz[s] / 16);
    end
    bus(1, ADDR_FLAGS, 32'h0000_0002);
    bus(1, ADDR_FLAGS, 32'h0000_0006);
    bus(1, ADDR_FLAGS, 32'h0000_0004);
    count(r);
    check(r, 512 / 16);
    bus(0, ADDR_FLAGS, 32'h0000_0004);
    hresetn <= 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    bus(0, ADDR_FLAGS, 32'h0000_0000);
    pin_is(1'b1);
    nvc <= 8'hff;
    nv_recall <= 1;
    @(posedge hclk);
    nv_recall <= 0;
    bus(0, ADDR_INT_CTRL, 32'h0000_001b);
    check(cfg, 8'h13);
    bus(1, ADDR_INT_CTRL, 32'h0000_0008);
    r = $urandom & 32'h0000_000f;
    bus(1, ADDR_IRQ_ENABLE, r);
    bus(0, ADDR_IRQ_ENABLE, r);
    bus(1, ADDR_IRQ_CLEAR, 32'h0000_000f);
    bus(1, ADDR_IRQ_ENABLE, 32'h0000_0000);
    pulse(2);
    bus(0, ADDR_IRQ_STATUS, 32'h0000_0002);
    check(irq, 1'b0);
    bus(1, ADDR_IRQ_ENABLE, 32'h0000_0002);
    pin_is(1'b1);
    check(irq, 1'b1);
    bus(1, ADDR_IRQ_CLEAR, 32'h0000_0002);
    pin_is(1'b1);
    check(irq, 1'b0);
    bus(0, ADDR_IRQ_CLEAR, 32'h0000_0000);
    // oscillator-fail must outlive a flags read, the event flags must not
    osc_f <= 1'b1;
    @(posedge hclk);
    osc_f <= 1'b0;
    bus(0, ADDR_FLAGS, 32'h0000_0030);
    bus(0, ADDR_FLAGS, 32'h0000_0010);
    conclude();
  end
endmodule
`default_nettype wire
